// ===== include/tsas_params.svh
`ifndef TSAS_PARAMS_SVH
`define TSAS_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TSAS_CLK_KHZ        125000
`define TSAS_YEL_SET_MS     600
`define TSAS_YEL_CLR_MS     200
`define TSAS_TOG_HOLD_MS    96

// ----------------------------------------------------------------
// counts and frame geometry
// ----------------------------------------------------------------
`define TSAS_BPV_THRESH     256
`define TSAS_FT_THRESH      4
`define TSAS_ROB_PERIOD     6
`define TSAS_SF_FRAMES      72
`define TSAS_DS1_LAST_POS   192
`define TSAS_NUM_DS0        24
`define TSAS_SLC_SYNC_PAT   12'h1c7
`define TSAS_ESF_YEL_PAT    16'h00ff

// ----------------------------------------------------------------
// register offsets (byte addresses) and reset values
// ----------------------------------------------------------------
`define TSAS_REG_CTRL       4'h0
`define TSAS_REG_DATACH     4'h4
`define TSAS_REG_SLC        4'h8
`define TSAS_REG_STAT       4'hc
`define TSAS_CTRL_RST       32'h0000_0000
`define TSAS_DATACH_RST     24'h00_0000
`define TSAS_SLC_RST        24'h00_0000

// control register fields
`define TSAS_CTRL_ESF       0
`define TSAS_CTRL_RBS_OFF   1
`define TSAS_CTRL_SLC       2

// slc field register layout
`define TSAS_SLC_X_LSB      0
`define TSAS_SLC_S_LSB      11
`define TSAS_SLC_C_LSB      15
`define TSAS_SLC_A_LSB      18
`define TSAS_SLC_L_LSB      20

// ----------------------------------------------------------------
// backplane channel map
// ----------------------------------------------------------------
`define TSAS_CH_PHASE       5'h03
`define TSAS_CH_MS1         5'h0f
`define TSAS_CH_MS2         5'h1f
`define TSAS_PC_LO_FIRST    5'h04
`define TSAS_PC_LO_LAST     5'h0e
`define TSAS_PC_HI_FIRST    5'h10
`define TSAS_PC_HI_LAST     5'h1c

// status word bit positions
`define TSAS_MS1_YEL        7
`define TSAS_MS1_MIMIC      6
`define TSAS_MS1_FTERR      5
`define TSAS_MS1_ESFYEL     4
`define TSAS_MS1_MFLOST     3
`define TSAS_MS1_BPV        2
`define TSAS_MS1_SLIP       1
`define TSAS_MS1_SYNLOST    0
`define TSAS_MS2_BLUE       7
`define TSAS_MS2_V128       4
`define TSAS_MS2_V64        3

`endif

// ===== include/tsas_pkg.sv
package tsas_pkg;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} tsas_avm_req_t;

	// rate-limited toggle: count, hold timer since last toggle, pending
	typedef struct packed {
		logic [8:0] cnt;
		logic [6:0] holdMs;
		logic       pending;
		logic       tog;
	} tsas_tog_t;

	typedef struct packed {
		logic [31:0]      ctrl;
		logic [23:0]      dataCh;
		logic [23:0]      slc;
		logic             ack;
		logic [31:0]      rdata;
		logic [19:0]      msDiv;
		logic             msTick;
		logic [7:0]       rxPos;
		logic             rxOdd;
		logic             rxFrmYel;
		logic             rxFrmOnes;
		logic             blue;
		logic             yelWinPat;
		logic [9:0]       yelSetMs;
		logic [9:0]       yelClrMs;
		logic             yelD4;
		logic [15:0]      fdlSh;
		logic             esfYel;
		logic [7:0]       candCnt;
		logic             mimic;
		tsas_tog_t        line_violation_toggle;
		tsas_tog_t        ft;
		logic [7:0]       vCnt;
		logic [7:0]       txPos;
		logic [6:0]       txFrame;
		logic [2:0]       txSub;
		logic [1:0]       txRob;
		logic             txOut;
		logic [4:0]       bpCh;
		logic [2:0]       bpBit;
		logic [7:0]       inSh;
		logic [23:0][3:0] sig;
		logic [7:0]       snapM1;
		logic [7:0]       snapM2;
		logic [7:0]       snapPh;
		logic [23:0][3:0] snapSig;
		logic             csOut;
	} tsas_state_t;

endpackage

// ===== verilog/tsas_core.sv
`include "tsas_params.svh"

// Function
// - abcd bits inserted only every sixth frame
// - input stream holds 24 per-channel abcd words
// - global disable bit stops all robbed signalling
// - per-channel data bit stops that channel
// - output stream: two masters, 24 channels, phase
// - d4 yellow after 600 ms bit2 zeros
// - d4 yellow released 200 ms after change
// - d4 yellow survives line errors
// - esf yellow on eight zeros, eight ones
// - blue alarm drops out on line errors
// - mimic set on multiple sync candidates
// - mimic cleared on resynchronization with at most one candidate
// - 72-frame subscriber-carrier framing pattern generated
// - violation bit toggles every 256 violations
// - that toggle at most every 96 ms
// - violations while a toggle is pending (threshold reached, hold not expired) are discarded
// - second bit toggles every 128 violations
// - third bit toggles every 64 violations
// - 128/64 bits free of hold time
// - word bit3 a, bit2 b, c d
// - framing error bit: four errors, 96 ms
// - format bit selects esf or d3/d4
module tsas_core
	import tsas_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `TSAS_CLK_KHZ
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire tsas_avm_req_t avmReq,
	output logic [31:0]        avmReadData,
	output logic               avmWaitRequest,
	input  wire logic          bpBitEn,
	input  wire logic          bpFrameStart,
	input  wire logic          control_serial_in_b,
	output logic               control_serial_out,
	input  wire logic          txBitEn,
	input  wire logic          txFrameStart,
	input  wire logic          txMfStart,
	input  wire logic          txBitIn,
	output logic               txBitOut,
	input  wire logic          rxBitEn,
	input  wire logic          rxFrameStart,
	input  wire logic          rxMfStart,
	input  wire logic          rxBit,
	input  wire logic          rxViolation,
	input  wire logic          rxFramingErr,
	input  wire logic          syncLost,
	input  wire logic          mfSyncLost,
	input  wire logic          slipToggle,
	input  wire logic          reframeStart,
	input  wire logic          syncCandidate,
	input  wire logic          syncAchieved,
	input  wire logic [7:0]    phaseWord
);

	tsas_state_t s_ff;
	tsas_state_t nxt_s;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// hold measured in whole ms ticks, so the gap is 95..96 ms
	function automatic tsas_tog_t togStep(tsas_tog_t t, logic ev, logic tick,
		logic [8:0] thr);
		tsas_tog_t n;
		n = t;
		if (tick && n.holdMs != 7'(`TSAS_TOG_HOLD_MS)) begin
			n.holdMs = n.holdMs + 7'h01;
		end
		if (ev && !n.pending) begin
			if (n.cnt == thr - 9'h001) begin
				n.cnt     = 9'h000;
				n.pending = 1'b1;
			end else begin
				n.cnt = n.cnt + 9'h001;
			end
		end
		if (n.pending && n.holdMs == 7'(`TSAS_TOG_HOLD_MS)) begin
			n.tog     = ~n.tog;
			n.pending = 1'b0;
			n.holdMs  = 7'h00;
		end
		return n;
	endfunction

	// backplane channel -> ds0 index, bit 5 flags a per-channel slot
	function automatic logic [5:0] chanMap(logic [4:0] ch);
		logic [5:0] r;
		r = 6'h00;
		if (ch >= `TSAS_PC_LO_FIRST && ch <= `TSAS_PC_LO_LAST) begin
			r = {1'b1, ch - `TSAS_PC_LO_FIRST};
		end else if (ch >= `TSAS_PC_HI_FIRST && ch <= `TSAS_PC_HI_LAST) begin
			r = {1'b1, ch - `TSAS_PC_HI_FIRST + 5'h0b};
		end
		return r;
	endfunction

	// frame index 0..71 -> framing bit of the 72-frame carrier format
	function automatic logic slcBit(logic [6:0] fr, logic [23:0] fld);
		logic [6:0] f;
		logic [5:0] e;
		logic       b;
		f = fr + 7'h01;
		e = f[6:1];
		b = 1'b0;
		if (f[0]) begin
			b = ~f[1];
		end else if (e <= 6'h0c) begin
			b = 1'(`TSAS_SLC_SYNC_PAT >> (4'hc - e[3:0]));
		end else if (e <= 6'h17) begin
			b = fld[`TSAS_SLC_X_LSB + 32'(e - 6'h0d)];
		end else if (e <= 6'h1a) begin
			b = fld[`TSAS_SLC_S_LSB + 32'(e - 6'h18)];
		end else if (e <= 6'h1d) begin
			b = fld[`TSAS_SLC_C_LSB + 32'(e - 6'h1b)];
		end else if (e <= 6'h1f) begin
			b = fld[`TSAS_SLC_A_LSB + 32'(e - 6'h1e)];
		end else if (e <= 6'h23) begin
			b = fld[`TSAS_SLC_L_LSB + 32'(e - 6'h20)];
		end else begin
			b = fld[`TSAS_SLC_S_LSB + 3];
		end
		return b;
	endfunction

	// ----------------------------------------------------------------
	// live status words
	// ----------------------------------------------------------------
	logic       esfMode;
	logic [7:0] liveM1;
	logic [7:0] liveM2;

	always_comb begin
		esfMode = s_ff.ctrl[`TSAS_CTRL_ESF];
		liveM1 = 8'h00;
		liveM1[`TSAS_MS1_YEL]     = s_ff.yelD4 & ~esfMode;
		liveM1[`TSAS_MS1_MIMIC]   = s_ff.mimic;
		liveM1[`TSAS_MS1_FTERR]   = s_ff.ft.tog;
		liveM1[`TSAS_MS1_ESFYEL]  = s_ff.esfYel & esfMode;
		liveM1[`TSAS_MS1_MFLOST]  = mfSyncLost;
		liveM1[`TSAS_MS1_BPV]     = s_ff.line_violation_toggle.tog;
		liveM1[`TSAS_MS1_SLIP]    = slipToggle;
		liveM1[`TSAS_MS1_SYNLOST] = syncLost;
		liveM2 = 8'h00;
		liveM2[`TSAS_MS2_BLUE] = s_ff.blue;
		liveM2[`TSAS_MS2_V128] = s_ff.vCnt[7];
		liveM2[`TSAS_MS2_V64]  = s_ff.vCnt[6];
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [5:0] map;
	logic [5:0] outMap;
	logic [7:0] outWord;
	logic [6:0] curFrame;
	logic [2:0] curSub;
	logic [1:0] curRob;
	logic [4:0] txCh;
	logic [1:0] sigSel;
	logic       maintenance_link_bits;
	logic [2:0] rxChBit;
	logic       avmReq_v;

	always_comb begin
		nxt_s    = s_ff;
		map      = 6'h00;
		outMap   = 6'h00;
		outWord  = 8'h00;
		curFrame = 7'h00;
		curSub   = 3'h0;
		curRob   = 2'h0;
		txCh     = 5'h00;
		sigSel   = 2'h0;
		maintenance_link_bits      = 1'b0;
		rxChBit  = 3'h0;
		avmReq_v = avmReq.read | avmReq.write;

		// register bus: one wait cycle, write lands at the completing edge
		nxt_s.ack = avmReq_v & ~s_ff.ack;
		if (avmReq_v && !s_ff.ack) begin
			case (avmReq.address)
				`TSAS_REG_CTRL:   nxt_s.rdata = s_ff.ctrl;
				`TSAS_REG_DATACH: nxt_s.rdata = {8'h00, s_ff.dataCh};
				`TSAS_REG_SLC:    nxt_s.rdata = {8'h00, s_ff.slc};
				`TSAS_REG_STAT:   nxt_s.rdata = {16'h0000, liveM2, liveM1};
				default:          nxt_s.rdata = 32'h0000_0000;
			endcase
		end
		if (avmReq.write && s_ff.ack) begin
			for (int i = 0; i < 4; i++) begin
				if (avmReq.byteenable[i]) begin
					case (avmReq.address)
						`TSAS_REG_CTRL: begin
							nxt_s.ctrl[i*8 +: 8] = (i == 0) ? (avmReq.writedata[7:0] & 8'h07) : 8'h00;
						end
						`TSAS_REG_DATACH: begin
							if (i < 3) nxt_s.dataCh[i*8 +: 8] = avmReq.writedata[i*8 +: 8];
						end
						`TSAS_REG_SLC: begin
							if (i < 3) nxt_s.slc[i*8 +: 8] = avmReq.writedata[i*8 +: 8];
						end
						default: ;
					endcase
				end
			end
		end

		// millisecond tick
		nxt_s.msTick = 1'b0;
		if (s_ff.msDiv == 20'(MS_CYCLES - 1)) begin
			nxt_s.msDiv  = 20'h00000;
			nxt_s.msTick = 1'b1;
		end else begin
			nxt_s.msDiv = s_ff.msDiv + 20'h00001;
		end

		// violation and framing error toggles, toggle counters restart at threshold, vCnt never cleared
		nxt_s.line_violation_toggle = togStep(s_ff.line_violation_toggle, rxViolation, s_ff.msTick, 9'(`TSAS_BPV_THRESH));
		nxt_s.ft  = togStep(s_ff.ft, rxFramingErr, s_ff.msTick, 9'(`TSAS_FT_THRESH));
		if (rxViolation) begin
			nxt_s.vCnt = s_ff.vCnt + 8'h01;
		end

		// mimic tracking
		if (reframeStart) begin
			nxt_s.candCnt = 8'h00;
		end else if (syncCandidate && s_ff.candCnt != 8'hff) begin
			nxt_s.candCnt = s_ff.candCnt + 8'h01;
		end
		if (syncAchieved) begin
			nxt_s.mimic = s_ff.candCnt > 8'h01;
		end

		// receive line monitor
		if (rxBitEn) begin
			if (rxFrameStart) begin
				nxt_s.rxPos = 8'h00;
				nxt_s.rxOdd = rxMfStart ? 1'b1 : ~s_ff.rxOdd;
				// close the previous frame
				if (s_ff.rxFrmYel) nxt_s.yelWinPat = 1'b1;
				nxt_s.blue      = s_ff.rxFrmOnes;
				nxt_s.rxFrmYel  = 1'b1;
				nxt_s.rxFrmOnes = 1'b1;
				maintenance_link_bits = esfMode && nxt_s.rxOdd;
				if (maintenance_link_bits) begin
					if (s_ff.esfYel && rxBit != s_ff.fdlSh[15]) nxt_s.esfYel = 1'b0;
					nxt_s.fdlSh = {s_ff.fdlSh[14:0], rxBit};
					if (nxt_s.fdlSh == `TSAS_ESF_YEL_PAT) nxt_s.esfYel = 1'b1;
				end
			end else if (s_ff.rxPos != 8'(`TSAS_DS1_LAST_POS)) begin
				nxt_s.rxPos = s_ff.rxPos + 8'h01;
				rxChBit = s_ff.rxPos[2:0];
				if (rxChBit == 3'h1 && rxBit) nxt_s.rxFrmYel = 1'b0;
				if (!rxBit) begin
					nxt_s.rxFrmOnes = 1'b0;
					nxt_s.blue      = 1'b0;
				end
			end
		end

		// d4 yellow: a ms with any alarm frame counts toward the alarm, so
		// isolated errored frames neither stop nor restart it
		if (s_ff.msTick) begin
			if (!(rxBitEn && rxFrameStart && s_ff.rxFrmYel)) nxt_s.yelWinPat = 1'b0; // set wins
			if (s_ff.yelWinPat) begin
				nxt_s.yelClrMs = 10'h000;
				if (s_ff.yelSetMs != 10'(`TSAS_YEL_SET_MS)) begin
					nxt_s.yelSetMs = s_ff.yelSetMs + 10'h001;
				end
				if (nxt_s.yelSetMs == 10'(`TSAS_YEL_SET_MS)) nxt_s.yelD4 = 1'b1;
			end else begin
				nxt_s.yelSetMs = 10'h000;
				if (s_ff.yelClrMs != 10'(`TSAS_YEL_CLR_MS)) begin
					nxt_s.yelClrMs = s_ff.yelClrMs + 10'h001;
				end
				if (nxt_s.yelClrMs == 10'(`TSAS_YEL_CLR_MS)) nxt_s.yelD4 = 1'b0;
			end
		end

		// transmit insertion
		if (txBitEn) begin
			if (txFrameStart) begin
				curFrame = txMfStart ? 7'h00 :
					(s_ff.txFrame == 7'(`TSAS_SF_FRAMES - 1) ? 7'h00 : s_ff.txFrame + 7'h01);
				curSub = (txMfStart || s_ff.txSub == 3'(`TSAS_ROB_PERIOD - 1)) ? 3'h0 :
					s_ff.txSub + 3'h1;
				curRob = txMfStart ? 2'h0 :
					(s_ff.txSub == 3'(`TSAS_ROB_PERIOD - 1) ? s_ff.txRob + 2'h1 : s_ff.txRob);
				nxt_s.txFrame = curFrame;
				nxt_s.txSub   = curSub;
				nxt_s.txRob   = curRob;
				nxt_s.txPos   = 8'h00;
				nxt_s.txOut   = s_ff.ctrl[`TSAS_CTRL_SLC] ? slcBit(curFrame, s_ff.slc) : txBitIn;
			end else begin
				nxt_s.txPos = (s_ff.txPos == 8'(`TSAS_DS1_LAST_POS)) ? s_ff.txPos : s_ff.txPos + 8'h01;
				txCh   = s_ff.txPos[7:3];
				sigSel = esfMode ? s_ff.txRob : {1'b0, s_ff.txRob[0]};
				nxt_s.txOut = txBitIn;
				if (s_ff.txPos != 8'(`TSAS_DS1_LAST_POS) && s_ff.txPos[2:0] == 3'h7 &&
					s_ff.txSub == 3'(`TSAS_ROB_PERIOD - 1) &&
					!s_ff.ctrl[`TSAS_CTRL_RBS_OFF] &&
					!s_ff.dataCh[txCh]) begin
					nxt_s.txOut = s_ff.sig[txCh][2'h3 - sigSel];
				end
			end
		end

		// backplane streams
		if (bpBitEn) begin
			if (bpFrameStart) begin
				nxt_s.bpCh    = 5'h00;
				nxt_s.bpBit   = 3'h0;
				nxt_s.snapM1  = liveM1;
				nxt_s.snapM2  = liveM2;
				nxt_s.snapPh  = phaseWord;
				nxt_s.snapSig = s_ff.sig;
			end else begin
				nxt_s.bpBit = s_ff.bpBit + 3'h1;
				if (s_ff.bpBit == 3'h7) nxt_s.bpCh = s_ff.bpCh + 5'h01;
			end
			nxt_s.inSh = {s_ff.inSh[6:0], control_serial_in_b};
			if (nxt_s.bpBit == 3'h7) begin
				map = chanMap(nxt_s.bpCh);
				if (map[5]) nxt_s.sig[map[4:0]] = nxt_s.inSh[3:0];
			end
			outMap = chanMap(nxt_s.bpCh);
			case (nxt_s.bpCh)
				`TSAS_CH_MS1:   outWord = nxt_s.snapM1;
				`TSAS_CH_MS2:   outWord = nxt_s.snapM2;
				`TSAS_CH_PHASE: outWord = nxt_s.snapPh;
				default:        outWord = outMap[5] ? {4'h0, nxt_s.snapSig[outMap[4:0]]} : 8'h00;
			endcase
			nxt_s.csOut = outWord[3'h7 - nxt_s.bpBit];
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_ff             <= '0;
			s_ff.ctrl        <= `TSAS_CTRL_RST;
			s_ff.dataCh      <= `TSAS_DATACH_RST;
			s_ff.slc         <= `TSAS_SLC_RST;
			s_ff.line_violation_toggle.holdMs  <= 7'(`TSAS_TOG_HOLD_MS);
			s_ff.ft.holdMs   <= 7'(`TSAS_TOG_HOLD_MS);
			s_ff.bpCh        <= 5'h1f;
			s_ff.bpBit       <= 3'h7;
			s_ff.txPos       <= 8'(`TSAS_DS1_LAST_POS);
			s_ff.rxPos       <= 8'(`TSAS_DS1_LAST_POS);
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign avmReadData        = s_ff.rdata;
	assign avmWaitRequest     = (avmReq.read | avmReq.write) & ~s_ff.ack;
	assign control_serial_out = s_ff.csOut;
	assign txBitOut           = s_ff.txOut;

endmodule

// ===== dv/tsas_core_checker.sv
module tsas_core_checker
	import tsas_pkg::*;
#(
	parameter int unsigned MS_CYCLES = 125000
) (
	input wire logic          clock,
	input wire logic          rst_n,
	input wire tsas_avm_req_t avmReq,
	input wire logic [31:0]   avmReadData,
	input wire logic          avmWaitRequest,
	input wire logic          bpBitEn,
	input wire logic          control_serial_out,
	input wire logic          txBitEn,
	input wire logic          txBitIn,
	input wire logic          txBitOut,
	input wire logic          rxViolation,
	input wire logic          reframeStart,
	input wire logic          syncCandidate,
	input wire logic          syncAchieved
);
	typedef struct packed {
		logic [2:0] ctrl;
		logic [9:0] vio;
		logic [7:0] cand;
		logic       mimic;
	} tsas_chk_t;
	tsas_chk_t s_ff;
	tsas_chk_t nxt_s;
	logic      req;
	logic      stRd;
	assign req = avmReq.read | avmReq.write;
	assign stRd = avmReq.read && !avmWaitRequest && avmReq.address == 4'hc;
	// shadow of what software wrote and what the receiver saw
	always_comb begin
		nxt_s = s_ff;
		if (avmReq.write && !avmWaitRequest && avmReq.address == 4'h0 && avmReq.byteenable[0])
			nxt_s.ctrl = avmReq.writedata[2:0];
		if (rxViolation)
			nxt_s.vio = s_ff.vio + 10'h001;
		if (reframeStart)
			nxt_s.cand = 8'h00;
		else if (syncCandidate)
			nxt_s.cand = s_ff.cand + 8'h01;
		if (syncAchieved)
			nxt_s.mimic = s_ff.cand > 8'h01;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	// ---
	// checks
	// ---
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence busTaken;
		req && avmWaitRequest;
	endsequence
	sequence busDone;
		req && !avmWaitRequest;
	endsequence
	one_wait_a: assert property (busTaken |=> busDone) else $error("wait state not one cycle");
	rbs_off_a: assert property (txBitEn && s_ff.ctrl[1] && !s_ff.ctrl[2] |=>
		txBitOut == $past(txBitIn)) else $error("robbed bit while disabled");
	v64_a: assert property (stRd |-> avmReadData[11] == $past(s_ff.vio[6]))
		else $error("64 toggle wrong");
	v128_a: assert property (stRd |-> avmReadData[12] == $past(s_ff.vio[7]))
		else $error("128 toggle wrong");
	mimic_a: assert property (stRd |-> avmReadData[6] == $past(s_ff.mimic))
		else $error("mimic flag wrong");
	sout_strobe_a: assert property ($changed(control_serial_out) |-> $past(bpBitEn))
		else $error("serial out moved off strobe");
	tx_strobe_a: assert property ($changed(txBitOut) |-> $past(txBitEn))
		else $error("tx bit moved off strobe");
	status_hi_a: assert property (stRd |-> avmReadData[31:16] == 16'h0000)
		else $error("status upper bits set");
	ctrl_read_a: assert property (avmReq.read && !avmWaitRequest && avmReq.address == 4'h0
		|-> avmReadData == {29'h0, s_ff.ctrl}) else $error("control readback wrong");
	yel_mode_a: assert property (stRd |-> (s_ff.ctrl[0] ? !avmReadData[7] : !avmReadData[4]))
		else $error("yellow of other format set");
endmodule

bind tsas_core tsas_core_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (.clock(clock), .rst_n(rst_n),
	.avmReq(avmReq), .avmReadData(avmReadData), .avmWaitRequest(avmWaitRequest),
	.bpBitEn(bpBitEn), .control_serial_out(control_serial_out), .txBitEn(txBitEn),
	.txBitIn(txBitIn), .txBitOut(txBitOut), .rxViolation(rxViolation),
	.reframeStart(reframeStart), .syncCandidate(syncCandidate), .syncAchieved(syncAchieved));

// ===== dv/tsas_ctrl_model.sv
module tsas_ctrl_model (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             control_serial_out,
	input  wire logic [23:0][3:0] abcd,
	output logic                  bpBitEn,
	output logic                  bpFrameStart,
	output logic                  control_serial_in_b,
	output logic [31:0][7:0]      seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] slot;
	logic [7:0] prv;
	logic [7:0] rxSh;
	logic [7:0] word;
	logic [4:0] ch;
	logic       ph;
	assign prv = slot - 8'h01;
	assign ch = slot[7:3];
	// ds0 0..10 sit on ch4..14, ds0 11..23 on ch16..28
	always_comb begin
		word = 8'h00;
		if (ch >= 5'h04 && ch <= 5'h0e)
			word = {4'h0, abcd[ch - 5'h04]};
		if (ch >= 5'h10 && ch <= 5'h1c)
			word = {4'h0, abcd[ch - 5'h05]};
	end
	// strobe every other clock; out bit of a slot is read at the next strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{ph, slot, rxSh, bpBitEn, bpFrameStart, control_serial_in_b} <= '0;
			seen <= '0;
		end else begin
			ph <= !ph;
			bpBitEn <= !ph;
			if (!ph) begin
				slot <= slot + 8'h01;
				bpFrameStart <= slot == 8'h00;
				control_serial_in_b <= word[3'h7 - slot[2:0]];
				rxSh <= {rxSh[6:0], control_serial_out};
				if (slot[2:0] == 3'h0)
					seen[prv[7:3]] <= {rxSh[6:0], control_serial_out};
			end
		end
	end
endmodule

// ===== dv/tsas_core_test.sv
`include "tsas_params.svh"

module tsas_core_test
	import tsas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int    MSC = 20;
	logic             clock = 1'b0;
	logic             rxEn = 1'b0, rxFs = 1'b0, rxMf = 1'b0, rxB = 1'b0;
	logic             rst_n = 1'b0;
	tsas_avm_req_t    avmReq = '0;
	logic [31:0]      avmReadData, q;
	logic             avmWaitRequest, bpBitEn, bpFrameStart, sIn, sOut, txBitOut;
	logic             txBitEn = 1'b0, txFrameStart = 1'b0, txMfStart = 1'b0, txBitIn = 1'b0;
	logic [1:0]       err = 2'h0;
	logic [2:0]       syncEv = 3'h0, stat3 = 3'h0, c;
	logic [7:0]       phase = 8'h00;
	logic [23:0][3:0] sg = '0;
	logic [31:0][7:0] seen;
	logic             pe, pv, line_violation_toggle = 1'b0, mim = 1'b0, ft = 1'b0;
	int               num_errors = 0, n_tests = 0, cyc = 0, vtot = 0, f, b, m;
	int               seed = 32'h3945379b;
	always #4 clock = ~clock;
	tsas_core #(.MS_CYCLES(MSC)) dut_u (.clock(clock), .rst_n(rst_n), .avmReq(avmReq),
		.avmReadData(avmReadData), .avmWaitRequest(avmWaitRequest), .bpBitEn(bpBitEn),
		.bpFrameStart(bpFrameStart), .control_serial_in_b(sIn), .control_serial_out(sOut),
		.txBitEn(txBitEn), .txFrameStart(txFrameStart), .txMfStart(txMfStart),
		.txBitIn(txBitIn), .txBitOut(txBitOut), .rxBitEn(rxEn), .rxFrameStart(rxFs),
		.rxMfStart(rxMf), .rxBit(rxB), .rxViolation(err[0]), .rxFramingErr(err[1]),
		.syncLost(stat3[0]), .mfSyncLost(stat3[2]), .slipToggle(stat3[1]),
		.reframeStart(syncEv[2]), .syncCandidate(syncEv[1]), .syncAchieved(syncEv[0]),
		.phaseWord(phase));
	tsas_ctrl_model ctl_u (.clock(clock), .rst_n(rst_n), .control_serial_out(sOut), .abcd(sg),
		.bpBitEn(bpBitEn), .bpFrameStart(bpFrameStart), .control_serial_in_b(sIn), .seen(seen));
	// ---
	// helpers
	// ---
	task automatic test_done();
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avmReq <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: d};
		do
			@(posedge clock);
		while (avmWaitRequest !== 1'b0);
		q = avmReadData;
		avmReq <= '0;
		@(posedge clock);
	endtask
	task automatic pulse(input logic [1:0] e, input logic [2:0] s, input int n);
		repeat (n) begin
			err <= e;
			syncEv <= s;
			@(posedge clock);
			err <= 2'h0;
			syncEv <= 3'h0;
			@(posedge clock);
		end
		vtot += e[0] ? n : 0;
	endtask
	// n frames of F plus 8 bits; fb feeds odd-frame F bits, e spoils every third frame
	task automatic rxFrm(input int n, input logic [7:0] d, input logic [15:0] fb, input logic e);
		for (int k = 0; k < 9 * n; k++) begin
			rxEn <= 1'b1;
			rxFs <= k % 9 == 0;
			rxMf <= k == 0;
			rxB <= (k % 9 == 0) ? fb[4'(15 - k / 18)] : d[3'(8 - k % 9)] ^ (e && k % 27 == 11);
			@(posedge clock);
		end
		rxEn <= 1'b0;
	endtask
	function automatic logic [31:0] expSt();
		return {19'h0, vtot[7], vtot[6], 4'h0, mim, ft, 1'b0, stat3[2], line_violation_toggle, stat3[1:0]};
	endfunction
	task automatic stat(input string nm);
		repeat (4) @(posedge clock);
		bus(1'b0, 4'hc, 32'h0);
		chk(expSt(), q, nm);
	endtask
	// ds0 0 is a data channel throughout
	function automatic logic expTx(input int f, input int b, input logic din);
		int ch;
		int r;
		ch = (b - 1) / 8;
		r = f / 6;
		if (b == 0)
			return c[2] ? ((f % 2) ? (f % 4 == 1) : (((f / 2 - 1) / 3) % 2 == 1)) : din;
		if (f % 6 != 0 || (b - 1) % 8 != 7 || c[1] || ch == 0)
			return din;
		return c[0] ? sg[ch][3 - (r - 1) % 4] : sg[ch][(r % 2) ? 3 : 2];
	endfunction
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			test_done();
		end
	end
	// ---
	// scenarios
	// ---
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		chk(32'h0, q, "ctrl reset");
		sg <= {$random(seed), $random(seed), $random(seed)};
		stat3 <= 3'($random(seed));
		phase <= 8'($random(seed));
		bus(1'b1, 4'h4, 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk(32'h1, q, "data channel reg");
		bus(1'b0, 4'h1, 32'h0);
		chk(32'h0, q, "unmapped");
		for (m = 1; m <= 4; m++) begin
			pulse(2'h1, 3'h0, 64);
			line_violation_toggle = m == 4;
			stat("violation steps");
		end
		pulse(2'h1, 3'h0, 356);
		stat("violation hold");
		repeat (1500) @(posedge clock);
		line_violation_toggle = 1'b0;
		stat("violation late toggle");
		repeat (2000) @(posedge clock);
		pulse(2'h1, 3'h0, 200);
		stat("dropped not counted");
		pulse(2'h1, 3'h0, 56);
		line_violation_toggle = 1'b1;
		stat("violation third toggle");
		pulse(2'h2, 3'h0, 4);
		ft = 1'b1;
		stat("framing error toggle");
		for (m = 2; m >= 1; m--) begin
			pulse(2'h0, 3'h4, 1);
			pulse(2'h0, 3'h2, m);
			pulse(2'h0, 3'h1, 1);
			mim = m > 1;
			stat("mimic");
		end
		repeat (1100) @(posedge clock);
		q = expSt();
		chk(q[7:0], seen[15], "status word 1");
		chk(q[15:8], seen[31], "status word 2");
		chk(phase, seen[3], "phase word");
		chk({4'h0, sg[0]}, seen[4], "ds0 0 word");
		chk({4'h0, sg[23]}, seen[28], "ds0 23 word");
		chk(8'h00, seen[1], "idle channel");
		for (m = 0; m < 4; m++) begin
			c = (m == 3) ? 3'h4 : 3'(m);
			bus(1'b1, 4'h0, {29'h0, c});
			pv = 1'b0;
			for (f = 1; f <= 24; f++) begin
				for (b = 0; b < 193; b++) begin
					txBitEn <= 1'b1;
					txFrameStart <= b == 0;
					txMfStart <= b == 0 && f == 1;
					txBitIn <= 1'($random(seed));
					@(posedge clock);
					if (pv)
						chk(pe, txBitOut, "tx bit");
					pv = 1'b1;
					pe = expTx(f, b, txBitIn);
				end
			end
			txBitEn <= 1'b0;
			stat("status per mode");
		end
		fork
			rxFrm((`TSAS_YEL_SET_MS + 20) * MSC / 9, 8'h00, 16'h0000, 1'b1);
			begin
				repeat ((`TSAS_YEL_SET_MS - 10) * MSC) @(posedge clock);
				bus(1'b0, 4'hc, 32'h0);
				chk(32'h0, q[7], "yellow early");
				repeat (20 * MSC) @(posedge clock);
				bus(1'b0, 4'hc, 32'h0);
				chk(32'h1, q[7], "yellow set");
			end
		join
		fork
			rxFrm((`TSAS_YEL_CLR_MS + 20) * MSC / 9, 8'hff, 16'h0000, 1'b0);
			begin
				repeat ((`TSAS_YEL_CLR_MS - 10) * MSC) @(posedge clock);
				bus(1'b0, 4'hc, 32'h0);
				chk(32'h3, {q[15], q[7]}, "yellow held");
				repeat (20 * MSC) @(posedge clock);
				bus(1'b0, 4'hc, 32'h0);
				chk(32'h2, {q[15], q[7]}, "yellow released");
			end
		join
		rxFrm(1, 8'h7f, 16'h0000, 1'b0);
		bus(1'b0, 4'hc, 32'h0);
		chk(32'h0, q[15], "blue drop");
		bus(1'b1, 4'h0, 32'h1);
		rxFrm(32, 8'hff, 16'h00ff, 1'b0);
		bus(1'b0, 4'hc, 32'h0);
		chk(32'h1, {q[7], q[4]}, "esf yellow");
		rxFrm(1, 8'hff, 16'hffff, 1'b0);
		bus(1'b0, 4'hc, 32'h0);
		chk(32'h0, q[4], "esf yellow drop");
		test_done();
	end
endmodule
